// [mwh_top.sv]
// Notes on behaviour
// - Enable in position mode copies motor to wheel.
// - Leaving position mode copies wheel to motor.
// - Outside position mode, control uses motor only.
// - Entering position mode later copies motor to wheel.
// - Mode stays enabled through non-position modes.
// - Last-encoder init: select toggle in position mode loads the other encoder from the last one used.
// - Without return to motor, wheel init kept.
// - Feed constant two: slip per wheel revolution.
// - Otherwise slip per external encoder revolution.
// - Slip beyond nonzero window raises difference error.
// - Peak register holds largest slip seen.
// - Peak writable; zero restarts capture.
// - Zero window disables slip monitoring.
// - Monitoring off: slip accumulates, cleared only when the mode is off or parked.
// - Select bit enables mode only in position mode.
// - Clear select, parameter phase or power-off exits.
// - Zero smoothing passes wheel; else filter difference.
// - Hybrid equals motor plus smoothed difference.
// - Entering mode clears references unless kept.
`timescale 1ns/10ps
`default_nettype none
module mwh_top
  import mwh_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic [WIDTH-1:0] motor_pos_in,
  input  wire logic [WIDTH-1:0] wheel_pos_in,
  input  wire logic             motor_ref_set_in,
  input  wire logic             wheel_ref_set_in,
  output logic      [WIDTH-1:0] motor_pos_out,
  output logic      [WIDTH-1:0] wheel_pos_out,
  output logic      [WIDTH-1:0] hybrid_pos_out,
  output logic                  active_out,
  output logic                  motor_ref_out,
  output logic                  wheel_ref_out,
  output logic                  feedback_difference_error_out
);

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  logic [31:0]      ctrl;
  logic [31:0]      smooth_tc;
  logic [31:0]      slip_window;
  logic [31:0]      rev_wheel;
  logic [31:0]      slip_pct;
  logic [31:0]      slip_peak;
  logic             slip_error;
  mwh_state_t       state;
  logic [WIDTH-1:0] motor_off;
  logic [WIDTH-1:0] wheel_off;
  logic             prev_pos_mode;
  logic             prev_sel;
  logic             wheel_last;
  logic [WIDTH-1:0] prev_motor;
  logic [WIDTH-1:0] prev_wheel;
  logic [31:0]      slip_acc;
  logic [31:0]      rev_count;

  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic             sel;
  logic             init_last;
  logic             feed2;
  logic             keep_ref;
  logic             pos_mode;
  logic             param_phase;
  logic [WIDTH-1:0] motor_eff;
  logic [WIDTH-1:0] wheel_eff;
  logic [WIDTH-1:0] smooth_diff;
  logic [WIDTH-1:0] next_hybrid;
  logic [31:0]      rev_len;
  logic [31:0]      step_abs;
  logic [31:0]      next_pct;
  logic             rev_done;
  logic             enter;
  logic             leave_pos;
  logic             enter_pos;
  logic             toggle;
  logic             monitor_on;

  function automatic logic [31:0] abs_diff(input logic [WIDTH-1:0] a,
                                           input logic [WIDTH-1:0] b);
    logic signed [WIDTH-1:0] d;
    d = $signed(a - b);
    abs_diff = 32'(d < 0 ? -d : d);
  endfunction

  function automatic logic [31:0] percent(input logic [31:0] amount,
                                          input logic [31:0] len);
    logic [63:0] prod;
    prod = 64'(amount) * 64'(PCT_SCALE);
    percent = (len == '0) ? '0 : 32'(prod / 64'(len));
  endfunction

  assign sel         = ctrl[CTRL_HYBRID_SEL_BIT];
  assign init_last   = ctrl[CTRL_INIT_LAST_BIT];
  assign feed2       = ctrl[CTRL_FEED2_BIT];
  assign keep_ref    = ctrl[CTRL_KEEP_REF_BIT];
  assign pos_mode    = ctrl[CTRL_POS_MODE_BIT];
  assign param_phase = ctrl[CTRL_PARAM_PHASE_BIT];

  // -------------------------------------------------------------------
  // APB slave
  // -------------------------------------------------------------------
  // Every access completes in its first access cycle; no wait states.
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  always_comb begin
    case (paddr_in)
      ADDR_CTRL, ADDR_SMOOTH, ADDR_WINDOW, ADDR_SLIP, ADDR_PEAK,
      ADDR_STATUS, ADDR_REV_LEN, ADDR_HYBRID: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
      if (rd_en) begin
        case (paddr_in)
          ADDR_CTRL:    prdata_out <= ctrl;
          ADDR_SMOOTH:  prdata_out <= smooth_tc;
          ADDR_WINDOW:  prdata_out <= slip_window;
          ADDR_SLIP:    prdata_out <= slip_pct;
          ADDR_PEAK:    prdata_out <= slip_peak;
          ADDR_STATUS:  prdata_out <= {27'h0, wheel_last, wheel_ref_out,
                                       motor_ref_out, slip_error,
                                       active_out};
          ADDR_REV_LEN: prdata_out <= rev_wheel;
          ADDR_HYBRID:  prdata_out <= 32'(hybrid_pos_out);
          default:      prdata_out <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl        <= RST_CTRL;
      smooth_tc   <= RST_SMOOTH;
      slip_window <= RST_WINDOW;
      rev_wheel   <= RST_REV1;
    end else if (wr_en && pready_out) begin
      case (paddr_in)
        ADDR_CTRL:    ctrl <= pwdata_in & 32'h0000_003F;
        ADDR_SMOOTH:  smooth_tc <= pwdata_in & 32'h0000_001F;
        ADDR_WINDOW:  slip_window <= pwdata_in;
        ADDR_REV_LEN: rev_wheel <= pwdata_in;
        default:      ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Mode control
  // -------------------------------------------------------------------
  assign enter     = (state == MWH_IDLE) && sel && pos_mode && !param_phase;
  assign leave_pos = (state == MWH_ACTIVE) && !pos_mode;
  assign enter_pos = (state == MWH_PARKED) && pos_mode;
  assign toggle    = (sel != prev_sel) && init_last;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= MWH_IDLE;
    end else if (!sel || param_phase) begin
      state <= MWH_IDLE;
    end else begin
      case (state)
        MWH_IDLE:   if (enter) state <= MWH_ACTIVE;
        MWH_ACTIVE: if (!pos_mode) state <= MWH_PARKED;
        MWH_PARKED: if (pos_mode) state <= MWH_ACTIVE;
        default:    state <= MWH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_sel      <= 1'b0;
      prev_pos_mode <= 1'b0;
    end else begin
      prev_sel      <= sel;
      prev_pos_mode <= pos_mode;
    end
  end

  // -------------------------------------------------------------------
  // Encoder initialization offsets
  // -------------------------------------------------------------------
  assign motor_eff = motor_pos_in + motor_off;
  assign wheel_eff = wheel_pos_in + wheel_off;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      motor_off  <= '0;
      wheel_off  <= '0;
      wheel_last <= 1'b0;
    end else if (init_last) begin
      if (toggle && prev_pos_mode) begin
        if (wheel_last) begin
          motor_off <= wheel_eff - motor_pos_in;
        end else begin
          wheel_off <= motor_eff - wheel_pos_in;
        end
      end
      // Wheel offset otherwise untouched so its first init survives.
      if (state == MWH_ACTIVE) begin
        wheel_last <= 1'b1;
      end else if (pos_mode) begin
        wheel_last <= 1'b0;
      end
    end else if (enter || enter_pos) begin
      wheel_off <= motor_eff - wheel_pos_in;
    end else if (leave_pos) begin
      motor_off <= wheel_eff - motor_pos_in;
    end
  end

  // -------------------------------------------------------------------
  // Reference flags
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      motor_ref_out <= 1'b0;
      wheel_ref_out <= 1'b0;
    end else if (enter && !keep_ref) begin
      motor_ref_out <= motor_ref_set_in;
      wheel_ref_out <= wheel_ref_set_in;
    end else begin
      motor_ref_out <= motor_ref_out | motor_ref_set_in;
      wheel_ref_out <= wheel_ref_out | wheel_ref_set_in;
    end
  end

  // -------------------------------------------------------------------
  // Hybrid position
  // -------------------------------------------------------------------
  mwh_smooth #(
    .WIDTH (WIDTH)
  ) u_smooth (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .clear_in   (state != MWH_ACTIVE),
    .shift_in   (smooth_tc[SMOOTH_BITS-1:0]),
    .diff_in    (wheel_eff - motor_eff),
    .smooth_out (smooth_diff)
  );

  always_comb begin
    if (state == MWH_ACTIVE) begin
      next_hybrid = motor_eff + smooth_diff;
    end else begin
      next_hybrid = motor_eff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hybrid_pos_out <= '0;
      motor_pos_out  <= '0;
      wheel_pos_out  <= '0;
      active_out     <= 1'b0;
    end else begin
      hybrid_pos_out <= next_hybrid;
      motor_pos_out  <= motor_eff;
      wheel_pos_out  <= wheel_eff;
      active_out     <= (state != MWH_IDLE);
    end
  end

  // -------------------------------------------------------------------
  // Slip computation and monitoring
  // -------------------------------------------------------------------
  // Raw counts are used, so an offset load is never taken for slip.
  assign rev_len    = feed2 ? rev_wheel : RST_REV2;
  assign step_abs   = abs_diff(wheel_pos_in - prev_wheel,
                               motor_pos_in - prev_motor);
  assign rev_done   = (rev_count + abs_diff(wheel_pos_in, prev_wheel))
                      >= rev_len;
  assign monitor_on = (slip_window != '0);
  assign next_pct   = percent(slip_acc + step_abs, rev_len);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_motor <= '0;
      prev_wheel <= '0;
      slip_acc   <= '0;
      rev_count  <= '0;
      slip_pct   <= '0;
    end else begin
      prev_motor <= motor_pos_in;
      prev_wheel <= wheel_pos_in;
      if (state != MWH_ACTIVE) begin
        slip_acc  <= '0;
        rev_count <= '0;
      end else if (rev_done && monitor_on) begin
        slip_acc  <= '0;
        rev_count <= '0;
        slip_pct  <= next_pct;
      end else begin
        slip_acc  <= slip_acc + step_abs;
        rev_count <= rev_done ? '0
                   : rev_count + abs_diff(wheel_pos_in, prev_wheel);
        slip_pct  <= next_pct;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slip_peak <= '0;
    end else if (slip_pct > slip_peak) begin
      slip_peak <= slip_pct;
    end else if (wr_en && pready_out && paddr_in == ADDR_PEAK) begin
      slip_peak <= pwdata_in;
    end
  end

  // Sticky until cleared; a new excess in the clear cycle still wins.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slip_error <= 1'b0;
    end else if (monitor_on && slip_pct > slip_window) begin
      slip_error <= 1'b1;
    end else if (wr_en && pready_out && paddr_in == ADDR_CTRL &&
                 pwdata_in[CTRL_ERR_CLEAR_BIT]) begin
      slip_error <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      feedback_difference_error_out <= 1'b0;
    end else begin
      feedback_difference_error_out <= slip_error;
    end
  end

endmodule
`default_nettype wire

// [mwh_pkg.sv]
package mwh_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_SMOOTH    = 8'h04;
  localparam logic [7:0] ADDR_WINDOW    = 8'h08;
  localparam logic [7:0] ADDR_SLIP      = 8'h0C;
  localparam logic [7:0] ADDR_PEAK      = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_REV_LEN   = 8'h18;
  localparam logic [7:0] ADDR_HYBRID    = 8'h1C;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_HYBRID_SEL_BIT  = 0;
  localparam int CTRL_INIT_LAST_BIT   = 1;
  localparam int CTRL_FEED2_BIT       = 2;
  localparam int CTRL_KEEP_REF_BIT    = 3;
  localparam int CTRL_POS_MODE_BIT    = 4;
  localparam int CTRL_PARAM_PHASE_BIT = 5;
  localparam int CTRL_ERR_CLEAR_BIT   = 6;

  // ------------------------------------------------------------------
  // Status register fields
  // ------------------------------------------------------------------
  localparam int STAT_ACTIVE_BIT  = 0;
  localparam int STAT_ERROR_BIT   = 1;
  localparam int STAT_REF1_BIT    = 2;
  localparam int STAT_REF2_BIT    = 3;
  localparam int STAT_WHEEL_BIT   = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_SMOOTH  = 32'h0000_0000;
  localparam logic [31:0] RST_WINDOW  = 32'h0000_0000;
  localparam logic [31:0] RST_REV1    = 32'h0000_1000;
  localparam logic [31:0] RST_REV2    = 32'h0000_1000;
  localparam logic [31:0] PCT_SCALE   = 32'h0000_0064;
  localparam int          SMOOTH_BITS = 5;

  typedef enum logic [1:0] {
    MWH_IDLE,
    MWH_ACTIVE,
    MWH_PARKED
  } mwh_state_t;

endpackage

// [mwh_smooth.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// First-order smoothing of the encoder difference
// ---------------------------------------------------------------------
module mwh_smooth
  import mwh_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   clear_in,
  input  wire logic [SMOOTH_BITS-1:0] shift_in,
  input  wire logic [WIDTH-1:0]       diff_in,
  output logic      [WIDTH-1:0]       smooth_out
);

  logic signed [WIDTH-1:0] acc;
  logic signed [WIDTH-1:0] step;

  // A shift of zero passes the raw difference, so the wheel alone counts.
  always_comb begin
    step = ($signed(diff_in) - acc) >>> shift_in;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      acc <= '0;
    end else if (shift_in == '0) begin
      acc <= $signed(diff_in);
    end else begin
      acc <= acc + step;
    end
  end

  assign smooth_out = acc;

endmodule
`default_nettype wire

// [mwh_enc_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// Motor encoder and frictional wheel encoder on one feed axis
// ---------------------------------------------------------------------
module mwh_enc_model #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             run_in,
  input  wire logic             slip_in,
  output logic      [WIDTH-1:0] motor_pos_out,
  output logic      [WIDTH-1:0] wheel_pos_out
);
  logic [1:0] phase;

  // While slipping, the wheel loses one count in every four, so the
  // exact slip is known from the two positions alone.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase         <= 2'h0;
      motor_pos_out <= '0;
      wheel_pos_out <= '0;
    end else if (run_in) begin
      phase         <= phase + 2'h1;
      motor_pos_out <= motor_pos_out + 1'b1;
      if (!(slip_in && phase == 2'h0)) begin
        wheel_pos_out <= wheel_pos_out + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [mwh_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module mwh_top_asserts
  import mwh_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  input  wire logic             pready_out,
  input  wire logic             pslverr_out,
  input  wire logic [WIDTH-1:0] motor_pos_out,
  input  wire logic [WIDTH-1:0] wheel_pos_out,
  input  wire logic [WIDTH-1:0] hybrid_pos_out,
  input  wire logic             active_out,
  input  wire logic             feedback_difference_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic        ctrl_wr;
  logic [31:0] win_copy;
  assign ctrl_wr = psel_in && penable_in && pwrite_in && pready_out
                   && paddr_in == ADDR_CTRL;

  // Shadow of the slip window, so a raised error can be tied to it.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      win_copy <= 32'h0000_0000;
    end else if (psel_in && penable_in && pwrite_in && pready_out
                 && paddr_in == ADDR_WINDOW) begin
      win_copy <= pwdata_in;
    end
  end

  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_park;
    ctrl_wr && active_out && pwdata_in[CTRL_HYBRID_SEL_BIT]
      && !pwdata_in[CTRL_PARAM_PHASE_BIT];
  endsequence
  sequence s_leave;
    ctrl_wr && (!pwdata_in[CTRL_HYBRID_SEL_BIT]
      || pwdata_in[CTRL_PARAM_PHASE_BIT]);
  endsequence

  a_ready_next: assert property (s_setup |=> pready_out)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_enter_refused: assert property (
    ctrl_wr && !pwdata_in[CTRL_POS_MODE_BIT] && !active_out
      |=> !active_out [*3])
    else $error("mode entered outside position mode");
  a_leave_mode: assert property (s_leave |-> ##[1:3] !active_out)
    else $error("mode not left");
  a_park_keeps: assert property (s_park |=> active_out [*4])
    else $error("mode dropped while parked");
  a_enter_copy: assert property (
    $rose(active_out) |=> wheel_pos_out == motor_pos_out)
    else $error("wheel not loaded from motor on entry");
  a_idle_motor: assert property (
    (!active_out && $stable(motor_pos_out)) [*3]
      |-> hybrid_pos_out == motor_pos_out)
    else $error("hybrid differs from motor outside mode");
  a_err_window: assert property (
    $rose(feedback_difference_error_out) |-> $past(win_copy) != 0)
    else $error("slip error with monitoring off");
  a_err_sticky: assert property (
    feedback_difference_error_out
      && !(ctrl_wr && pwdata_in[CTRL_ERR_CLEAR_BIT])
      && !$past(ctrl_wr && pwdata_in[CTRL_ERR_CLEAR_BIT])
      |=> feedback_difference_error_out)
    else $error("slip error dropped without clear");
endmodule

bind mwh_top mwh_top_asserts #(.WIDTH(WIDTH)) u_asserts (
  .clk_in                        (clk_in),
  .reset_in                      (reset_in),
  .psel_in                       (psel_in),
  .penable_in                    (penable_in),
  .pwrite_in                     (pwrite_in),
  .paddr_in                      (paddr_in),
  .pwdata_in                     (pwdata_in),
  .pready_out                    (pready_out),
  .pslverr_out                   (pslverr_out),
  .motor_pos_out                 (motor_pos_out),
  .wheel_pos_out                 (wheel_pos_out),
  .hybrid_pos_out                (hybrid_pos_out),
  .active_out                    (active_out),
  .feedback_difference_error_out (feedback_difference_error_out)
);
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module tb
  import mwh_pkg::*;
;
  logic        clk_in, reset_in, psel, penable, pwrite, pready, perr;
  logic        pslverr, run, slip, mref_set, wref_set, act, mref, wref, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mp, wp, mo, wo, ho;
  logic [31:0] q, woff, moff, d0, lag, s1, s2;
  int          fails, total_checks, cycles;

  mwh_enc_model u_enc (.clk_in(clk_in), .reset_in(reset_in), .run_in(run),
    .slip_in(slip), .motor_pos_out(mp), .wheel_pos_out(wp));
  mwh_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .motor_pos_in(mp), .wheel_pos_in(wp),
    .motor_ref_set_in(mref_set), .wheel_ref_set_in(wref_set),
    .motor_pos_out(mo), .wheel_pos_out(wo), .hybrid_pos_out(ho),
    .active_out(act), .motor_ref_out(mref), .wheel_ref_out(wref),
    .feedback_difference_error_out(err));

  task stop_test;
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer, then a few idle cycles so the mode logic settles.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK("pready", 1'b1, n == 1)
  endtask

  task automatic move(input int n, input logic s);
    run <= 1'b1; slip <= s;
    repeat (n) @(posedge clk_in);
    run <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic refs_set();
    mref_set <= 1'b1; wref_set <= 1'b1;
    @(posedge clk_in);
    mref_set <= 1'b0; wref_set <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    {reset_in, psel, penable, pwrite, run, slip} = 6'h21;
    {mref_set, wref_set, paddr, pwdata} = '0;
    {fails, total_checks, cycles} = '0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    `CHK("act_rst", 1'b0, act)
    apb(0, ADDR_CTRL, 0);       `CHK("ctrl_rst", RST_CTRL, q)
    apb(0, ADDR_WINDOW, 0);     `CHK("win_rst", RST_WINDOW, q)
    apb(0, ADDR_REV_LEN, 0);    `CHK("rev_rst", RST_REV1, q)
    apb(0, 8'h20, 0);           `CHK("unmapped", 33'h1_0000_0000, {perr, q})
    refs_set();                 `CHK("refs", 2'h3, {mref, wref})
    move(40, 1);                `CHK("hyb_idle", mp, ho)
    apb(1, ADDR_CTRL, 32'h0000_0001); `CHK("refused", 1'b0, act)
    apb(1, ADDR_REV_LEN, 32'h0000_0040);
    woff = mp - wp;
    apb(1, ADDR_CTRL, 32'h0000_0015); `CHK("enter", 1'b1, act)
    `CHK("wheel_init", mp, wo)
    `CHK("refs_clr", 2'h0, {mref, wref})
    move(40, 1);                `CHK("hyb_act", wp + woff, ho)
    apb(1, ADDR_CTRL, 32'h0000_0005); `CHK("parked", 1'b1, act)
    `CHK("motor_init", wp + woff, mo)
    moff = wp + woff - mp;
    move(20, 1);                `CHK("hyb_park", mp + moff, ho)
    apb(1, ADDR_CTRL, 32'h0000_0015); `CHK("reenter", mp + moff, wo)
    apb(1, ADDR_WINDOW, 32'h0000_FFFF);
    move(200, 0);
    apb(1, ADDR_WINDOW, 32'h0000_0000);
    d0 = mp - wp;
    move(400, 1);
    lag = mp - wp - d0;
    s1 = lag * 32'h0000_0064 / 32'h0000_0040;
    s2 = lag * 32'h0000_0064 / 32'h0000_1000;
    `CHK("no_err", 1'b0, err)
    apb(0, ADDR_SLIP, 0);       `CHK("slip_wheel", s1, q)
    apb(0, ADDR_PEAK, 0);       `CHK("peak", s1, q)
    apb(1, ADDR_CTRL, 32'h0000_0011);
    apb(0, ADDR_SLIP, 0);       `CHK("slip_ext", s2, q)
    apb(0, ADDR_PEAK, 0);       `CHK("peak_hold", s1, q)
    apb(1, ADDR_PEAK, 0);
    apb(0, ADDR_PEAK, 0);       `CHK("peak_new", s2, q)
    apb(1, ADDR_CTRL, 32'h0000_0015);
    apb(1, ADDR_WINDOW, s1 - 1); `CHK("slip_err", 1'b1, err)
    apb(1, ADDR_WINDOW, 32'h0000_0000);
    apb(1, ADDR_CTRL, 32'h0000_0055); `CHK("err_clr", 1'b0, err)
    apb(1, ADDR_CTRL, 32'h0000_0035); `CHK("param_exit", 1'b0, act)
    refs_set();
    apb(1, ADDR_CTRL, 32'h0000_001D); `CHK("keep_ref", 2'h3, {mref, wref})
    apb(0, ADDR_STATUS, 0);     `CHK("status", 32'h0000_000D, q)
    apb(1, ADDR_CTRL, 32'h0000_0000); `CHK("sel_exit", 1'b0, act)
    apb(1, ADDR_CTRL, 32'h0000_0012);
    apb(1, ADDR_SMOOTH, 32'h0000_0003);
    move(20, 1);
    apb(1, ADDR_CTRL, 32'h0000_0013); `CHK("last_whl", mo, wo)
    move(40, 1);
    apb(0, ADDR_SMOOTH, 0);     `CHK("smooth", 32'h0000_0003, q)
    `CHK("hyb_smooth", wo, ho)
    s1 = wo;
    apb(1, ADDR_CTRL, 32'h0000_0012); `CHK("last_mot", s1, mo)
    `CHK("wheel_kept", s1, wo)
    stop_test();
  end
endmodule
`default_nettype wire
